// [logic/run_edge_irq.v]
// single-cycle interrupt request from the run bit falling edge or a time-out stop
`timescale 1ns/100ps
`include "uart_tx_dma_defs.vh"

module run_edge_irq
(
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // events
  input wire run,
  input wire irq_enable,
  input wire timeout_stop,
  // request
  output reg irq
);

reg run_prev;

always @(posedge sys_clk or posedge sys_rst)
begin
  if (sys_rst)
  begin
    run_prev <= `BIT_RESET;
    irq <= 1'b0;
  end
  else
  begin
    run_prev <= run;
    // a time-out stop interrupts even with completion interrupts masked
    irq <= (run_prev & ~run & irq_enable) | timeout_stop; // R8 R9 R10 R19
  end
end

endmodule // run_edge_irq

// [logic/tx_byte_mover.v]
// moves a counted run of bytes from a shared buffer into the uart holding register
`timescale 1ns/100ps
`include "uart_tx_dma_defs.vh"

module tx_byte_mover
(
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // control
  input wire start,
  input wire abort,
  input wire [`BC_W-1:0] count,
  output reg done,
  output reg [`BC_W-1:0] sent,
  // buffer memory read
  output reg sram_rd_req,
  output reg [`BC_W-1:0] sram_rd_index,
  input wire sram_rd_valid,
  input wire [`DATA_W-1:0] sram_rd_data,
  // uart holding register
  input wire thr_ready,
  output reg thr_wr,
  output reg [`DATA_W-1:0] thr_data
);

localparam S_IDLE = 2'h0;
localparam S_READ = 2'h1;
localparam S_PUSH = 2'h2;

reg [1:0] state;
reg [`BC_W-1:0] total;
// fetched byte waits here so the holding register only changes with its strobe
reg [`DATA_W-1:0] byte_q;

always @(posedge sys_clk or posedge sys_rst)
begin
  if (sys_rst)
  begin
    state <= S_IDLE;
    total <= `BC_ZERO;
    sent <= `BC_ZERO;
    done <= 1'b0;
    sram_rd_req <= 1'b0;
    sram_rd_index <= `BC_ZERO;
    thr_wr <= 1'b0;
    thr_data <= `ZERO_BYTE;
    byte_q <= `ZERO_BYTE;
  end
  else
  begin
    done <= 1'b0;
    sram_rd_req <= 1'b0;
    thr_wr <= 1'b0;
    if (abort)
      state <= S_IDLE;
    else
    begin
      case (state)
        S_IDLE:
          if (start)
          begin
            total <= count;
            sent <= `BC_ZERO;
            sram_rd_index <= `BC_ZERO;
            sram_rd_req <= 1'b1;
            state <= S_READ;
          end
        S_READ:
          if (sram_rd_valid)
          begin
            byte_q <= sram_rd_data;
            state <= S_PUSH;
          end
        S_PUSH:
          // one byte per holding-register slot; a stalled uart stalls the channel
          if (thr_ready)
          begin
            thr_wr <= 1'b1; // R18
            thr_data <= byte_q; // R18
            sent <= sent + `BC_ONE;
            if (sent + `BC_ONE == total)
            begin
              done <= 1'b1;
              state <= S_IDLE;
            end
            else
            begin
              sram_rd_index <= sram_rd_index + `BC_ONE;
              sram_rd_req <= 1'b1;
              state <= S_READ;
            end
          end
        default:
          state <= S_IDLE;
      endcase
    end
  end
end

endmodule // tx_byte_mover

// [logic/uart_tx_dma_channel.v]
// transmit dma channel: definition and status registers, buffer sequencing, halt handling
//
// Notes on behaviour
// [R1] three-bit pointer field selects the endpoint descriptor block set used
// [R2] direction bit always reads 1 and ignores writes
// [R3] buffer select bit 4: 0 means X buffer next, 1 means Y
// [R4] software always writes continuous mode bit 5 as 1
// [R5] channel updates buffer select itself; buffer manager follows it
// [R6] while running, alternate X and Y buffers without processor help
// [R7] byte count below buffer size: send partial packet, terminate, signal completion
// [R8] transaction timer expiry terminates channel and interrupts processor
// [R9] interrupt enable 0: no completion interrupt, partial packet keeps channel running
// [R10] interrupt enable 1: interrupt on every run bit falling edge
// [R11] processor starts transfer by writing 1 to run bit
// [R12] hardware clears run bit on completion or error termination
// [R13] halt when byte count reaches zero or on time-out
// [R14] on halt write back byte count and clear hold flag in descriptor
// [R15] partial packet flag set by channel, cleared only by processor
// [R16] status bits 7 to 1 read as zero
// [R17] all definition fields and partial packet flag reset to 0
// [R18] each byte moved is written into the uart holding register
// [R19] completion interrupt is a one-cycle pulse on run falling edge
// [R20] run write wins over same-cycle hardware clear only if previously idle; here the hardware clear always wins
`timescale 1ns/100ps
`include "uart_tx_dma_defs.vh"

module uart_tx_dma_channel
(
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // register port
  input wire [`ADDR_W-1:0] reg_addr,
  input wire [`DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`DATA_W-1:0] reg_rdata,
  // usb buffer manager and descriptor
  input wire ubm_buf_ready,
  input wire [`BC_W-1:0] ubm_byte_count,
  input wire [`BC_W-1:0] desc_buf_size,
  output reg [2:0] endpoint_descriptor_block,
  output reg buffer_select,
  output reg buf_done,
  // descriptor write-back on halt
  output reg desc_wb,
  output reg [`BC_W-1:0] desc_wb_count,
  output reg desc_wb_hold,
  // buffer memory read
  output wire sram_rd_req,
  output wire [`BC_W-1:0] sram_rd_index,
  input wire sram_rd_valid,
  input wire [`DATA_W-1:0] sram_rd_data,
  // uart holding register
  input wire thr_ready,
  output wire uart_tx_holding_wr,
  output wire [`DATA_W-1:0] uart_tx_holding_reg,
  // transaction timer
  input wire txn_timeout,
  // processor interrupt
  output wire irq
);

localparam ST_IDLE = 2'h0;
localparam ST_WAIT = 2'h1;
localparam ST_MOVE = 2'h2;
localparam ST_HALT = 2'h3;

// address match used by both the write and the read decode
function addr_hit;
  input [`ADDR_W-1:0] addr;
  input [`ADDR_W-1:0] offset;
  begin
    addr_hit = (addr == offset);
  end
endfunction

reg [1:0] state;
reg continuous_mode;
reg completion_irq_enable;
reg run;
reg partial_packet_flag;
reg short_pkt;
reg [`BC_W-1:0] cur_count;
reg mover_start;
reg mover_abort;
reg halt_by_timeout;
reg timeout_stop;

wire mover_done;
wire [`BC_W-1:0] mover_sent;
wire def_wr;
wire csr_wr;
wire sw_run_set;
wire hw_clear;
wire partial_packet_flag_set;
wire partial_packet_flag_clr;
wire [`DATA_W-1:0] def_value;
wire [`DATA_W-1:0] csr_value;

assign def_wr = reg_wr && addr_hit(reg_addr, `DEF_OFFSET);
assign csr_wr = reg_wr && addr_hit(reg_addr, `CSR_OFFSET);
assign sw_run_set = def_wr && reg_wdata[`RUN_BIT];
assign hw_clear = (state == ST_HALT); // R12
assign partial_packet_flag_set = (state == ST_MOVE) && mover_done && short_pkt && run;
assign partial_packet_flag_clr = csr_wr && reg_wdata[`PARTIAL_PACKET_FLAG_BIT];

assign def_value = {run, completion_irq_enable, continuous_mode, buffer_select,
  `DIR_TX, endpoint_descriptor_block}; // R2
assign csr_value = {{(`DATA_W-1){1'b0}}, partial_packet_flag}; // R16

// channel definition fields
always @(posedge sys_clk or posedge sys_rst)
begin
  if (sys_rst)
  begin
    endpoint_descriptor_block <= `PTR_RESET; // R17
    continuous_mode <= `BIT_RESET;
    completion_irq_enable <= `BIT_RESET;
  end
  else if (def_wr)
  begin
    endpoint_descriptor_block <= reg_wdata[`PTR_MSB:`PTR_LSB]; // R1
    // software is expected to keep this at 1; the channel runs continuously either way
    continuous_mode <= reg_wdata[`CNT_BIT]; // R4
    completion_irq_enable <= reg_wdata[`INE_BIT];
  end
end

// run bit: started by software, cleared by hardware on halt
always @(posedge sys_clk or posedge sys_rst)
begin
  if (sys_rst)
    run <= `BIT_RESET; // R17
  else if (hw_clear && !(sw_run_set && state == ST_IDLE))
    run <= 1'b0; // R12 R20
  else if (def_wr)
    run <= reg_wdata[`RUN_BIT]; // R11
end

// buffer select: software may preset it, the channel toggles after each buffer
always @(posedge sys_clk or posedge sys_rst)
begin
  if (sys_rst)
    buffer_select <= `BIT_RESET; // R17
  else if (state == ST_MOVE && mover_done && run)
    buffer_select <= ~buffer_select; // R3 R5 R6
  else if (def_wr)
    buffer_select <= reg_wdata[`XY_BIT];
end

// partial packet flag: a set in the same cycle as a clear wins
always @(posedge sys_clk or posedge sys_rst)
begin
  if (sys_rst)
    partial_packet_flag <= `BIT_RESET; // R17
  else if (partial_packet_flag_set)
    partial_packet_flag <= 1'b1; // R15
  else if (partial_packet_flag_clr)
    partial_packet_flag <= 1'b0; // R15
end

// read data stands for exactly one cycle after the strobe
always @(posedge sys_clk or posedge sys_rst)
begin
  if (sys_rst)
    reg_rdata <= `ZERO_BYTE;
  else if (reg_rd && addr_hit(reg_addr, `DEF_OFFSET))
    reg_rdata <= def_value;
  else if (reg_rd && addr_hit(reg_addr, `CSR_OFFSET))
    reg_rdata <= csr_value;
  else
    reg_rdata <= `ZERO_BYTE;
end

// buffer sequencer
always @(posedge sys_clk or posedge sys_rst)
begin
  if (sys_rst)
  begin
    state <= ST_IDLE;
    cur_count <= `BC_ZERO;
    short_pkt <= 1'b0;
    mover_start <= 1'b0;
    mover_abort <= 1'b0;
    halt_by_timeout <= 1'b0;
    timeout_stop <= 1'b0;
    buf_done <= 1'b0;
    desc_wb <= 1'b0;
    desc_wb_count <= `BC_ZERO;
    desc_wb_hold <= 1'b0;
  end
  else
  begin
    mover_start <= 1'b0;
    mover_abort <= 1'b0;
    timeout_stop <= 1'b0;
    buf_done <= 1'b0;
    desc_wb <= 1'b0;
    case (state)
      ST_IDLE:
      begin
        halt_by_timeout <= 1'b0;
        if (run)
          state <= ST_WAIT;
      end
      ST_WAIT:
      begin
        if (!run)
          state <= ST_IDLE;
        else if (txn_timeout)
        begin
          halt_by_timeout <= 1'b1; // R13
          desc_wb_count <= `BC_ZERO;
          state <= ST_HALT;
        end
        else if (ubm_buf_ready)
        begin
          if (ubm_byte_count == `BC_ZERO)
          begin
            desc_wb_count <= `BC_ZERO; // R13
            state <= ST_HALT;
          end
          else
          begin
            cur_count <= ubm_byte_count;
            short_pkt <= (ubm_byte_count < desc_buf_size); // R7
            mover_start <= 1'b1;
            state <= ST_MOVE;
          end
        end
      end
      ST_MOVE:
      begin
        if (!run)
        begin
          // software stop: drop the buffer without a write-back
          mover_abort <= 1'b1;
          state <= ST_IDLE;
        end
        else if (txn_timeout)
        begin
          mover_abort <= 1'b1;
          halt_by_timeout <= 1'b1; // R8 R13
          desc_wb_count <= cur_count - mover_sent;
          state <= ST_HALT;
        end
        else if (mover_done)
        begin
          buf_done <= 1'b1; // R6
          if (short_pkt && completion_irq_enable)
          begin
            desc_wb_count <= `BC_ZERO; // R7
            state <= ST_HALT;
          end
          else
            state <= ST_WAIT; // R6 R9
        end
      end
      ST_HALT:
      begin
        desc_wb <= 1'b1; // R14
        desc_wb_hold <= 1'b0; // R14
        timeout_stop <= halt_by_timeout; // R8
        state <= ST_IDLE;
      end
      default:
        state <= ST_IDLE;
    endcase
  end
end

tx_byte_mover u_mover
(
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .start(mover_start),
  .abort(mover_abort),
  .count(cur_count),
  .done(mover_done),
  .sent(mover_sent),
  .sram_rd_req(sram_rd_req),
  .sram_rd_index(sram_rd_index),
  .sram_rd_valid(sram_rd_valid),
  .sram_rd_data(sram_rd_data),
  .thr_ready(thr_ready),
  .thr_wr(uart_tx_holding_wr),
  .thr_data(uart_tx_holding_reg)
);

run_edge_irq u_irq
(
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .run(run),
  .irq_enable(completion_irq_enable),
  .timeout_stop(timeout_stop),
  .irq(irq)
);

endmodule // uart_tx_dma_channel

// [logic/uart_tx_dma_defs.vh]
// constants shared by the transmit dma channel files
`ifndef UART_TX_DMA_DEFS_VH
`define UART_TX_DMA_DEFS_VH

// register bus
`define ADDR_W 16
`define DATA_W 8
`define DEF_OFFSET 16'hFFE0
`define CSR_OFFSET 16'hFFE1

// channel definition register fields
`define PTR_LSB 0
`define PTR_MSB 2
`define DIR_BIT 3
`define XY_BIT 4
`define CNT_BIT 5
`define INE_BIT 6
`define RUN_BIT 7

// status register fields
`define PARTIAL_PACKET_FLAG_BIT 0

// reset and fixed values
`define PTR_RESET 3'h0
`define BIT_RESET 1'h0
`define DIR_TX 1'h1
`define ZERO_BYTE 8'h00

// byte counts
`define BC_W 7
`define BC_ZERO 7'h00
`define BC_ONE 7'h01

`endif

// [tb/tb_top.sv]
// self-checking bench for the transmit dma channel
`timescale 1ns/100ps
`include "uart_tx_dma_defs.vh"

module tb_top;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [`ADDR_W-1:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic txn_timeout = 1'b0;
  logic slow = 1'b0;
  logic [7:0] reg_rdata, uart_tx_holding_reg, sram_rd_data, v;
  logic [6:0] ubm_byte_count, desc_wb_count, sram_rd_index;
  logic [2:0] endpoint_descriptor_block;
  logic buffer_select, buf_done, desc_wb, desc_wb_hold, sram_rd_req, sram_rd_valid;
  logic ubm_buf_ready, thr_ready, uart_tx_holding_wr, uart_tx_holding_wr_d, irq, rd_d;
  logic [7:0] exp_rd[$], exp_tx[$], exp_wb[$];
  logic [7:0] n_irq = 8'h00;
  int n_errors = 0, samples_checked = 0, seed = 72051;

  always #2 sys_clk = ~sys_clk;

  uart_tx_dma_channel uart_tx_dma_channel_i (.desc_buf_size(7'h04), .*);
  ubm_uart_model ubm_uart_model_i (.*);

  task automatic report_and_stop();
    if (n_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    exp_rd.push_back(e);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
  endtask

  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic load(input int n, input logic xy);
    for (int j = 0; j < n; j++)
      exp_tx.push_back({xy, 7'(j)});
    ubm_uart_model_i.add_buf(n);
  endtask

  task automatic drain();
    int k;
    k = 0;
    idle(1);
    while ((exp_tx.size() != 0 || exp_wb.size() != 0) && k < 4000)
    begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 4000)
    begin
      n_errors++;
      report_and_stop();
    end
    idle(8);
  endtask

  // results are matched against the oldest note of their stream
  always @(posedge sys_clk) rd_d <= reg_rd;
  always @(negedge sys_clk)
  begin
    if (rd_d === 1'b1)
      check(reg_rdata, exp_rd.pop_front());
    if (uart_tx_holding_wr === 1'b1)
      check(uart_tx_holding_reg, exp_tx.pop_front());
    if (desc_wb === 1'b1)
      check({1'b0, desc_wb_count}, exp_wb.pop_front());
    if (irq === 1'b1)
      n_irq <= n_irq + 8'h01;
  end

  initial
  begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd(`DEF_OFFSET, 8'h08);
    rd(`CSR_OFFSET, 8'h00);
    rd(16'hFFE2, 8'h00);
    repeat (4)
    begin
      v = ($random(seed) & 8'h5F) | 8'h20;
      wr(`DEF_OFFSET, v);
      rd(`DEF_OFFSET, v | 8'h08);
      idle(1);
      check({5'h00, endpoint_descriptor_block}, {5'h00, v[2:0]});
      check({7'h00, buffer_select}, {7'h00, v[4]});
    end
    wr(`CSR_OFFSET, 8'hFF);
    rd(`CSR_OFFSET, 8'h00);
    // stalled far side, two full buffers then a short one
    slow <= 1'b1;
    load(4, 1'b0);
    load(4, 1'b1);
    load(2, 1'b0);
    exp_wb.push_back(8'h00);
    wr(`DEF_OFFSET, 8'hE0);
    drain();
    check(n_irq, 8'h01);
    rd(`DEF_OFFSET, 8'h78);
    rd(`CSR_OFFSET, 8'h01);
    wr(`CSR_OFFSET, 8'h01);
    rd(`CSR_OFFSET, 8'h00);
    slow <= 1'b0;
    load(2, 1'b0);
    wr(`DEF_OFFSET, 8'hA0);
    drain();
    rd(`DEF_OFFSET, 8'hB8);
    rd(`CSR_OFFSET, 8'h01);
    load(0, 1'b0);
    exp_wb.push_back(8'h00);
    drain();
    check(n_irq, 8'h01);
    // time-out while waiting for a buffer
    wr(`DEF_OFFSET, 8'hA0);
    exp_wb.push_back(8'h00);
    idle(3);
    txn_timeout <= 1'b1;
    @(posedge sys_clk);
    txn_timeout <= 1'b0;
    drain();
    check(n_irq, 8'h02);
    rd(`DEF_OFFSET, 8'h28);
    wr(`DEF_OFFSET, 8'hE0);
    idle(3);
    wr(`DEF_OFFSET, 8'h60);
    idle(4);
    check(n_irq, 8'h03);
    report_and_stop();
  end
endmodule // tb_top

// [tb/uart_tx_dma_channel_asserts.sv]
// assertion checker bound to the transmit dma channel
`timescale 1ns/100ps
`include "uart_tx_dma_defs.vh"

module dma_chk
(
  // clock, reset, register port
  input wire sys_clk,
  input wire sys_rst,
  input wire [`ADDR_W-1:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [`DATA_W-1:0] reg_rdata,
  // transfer side
  input wire buffer_select,
  input wire buf_done,
  input wire desc_wb,
  input wire desc_wb_hold,
  input wire thr_ready,
  input wire uart_tx_holding_wr,
  input wire [`DATA_W-1:0] uart_tx_holding_reg,
  input wire irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  property p_dir;
    $past(reg_rd) && $past(reg_addr) == `DEF_OFFSET |-> reg_rdata[`DIR_BIT];
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction bit read low");
  property p_csr;
    $past(reg_rd) && $past(reg_addr) == `CSR_OFFSET |-> reg_rdata[7:1] == 7'h00;
  endproperty
  a_csr: assert property (p_csr)
    else $error("status upper bits not zero");
  property p_hold;
    desc_wb |-> !desc_wb_hold;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold flag set on write-back");
  property p_irq;
    irq |=> !irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt longer than one cycle");
  property p_flip;
    buf_done |-> buffer_select != $past(buffer_select);
  endproperty
  a_flip: assert property (p_flip)
    else $error("buffer select did not toggle");
  property p_keep;
    !buf_done && !$past(reg_wr) |-> $stable(buffer_select);
  endproperty
  a_keep: assert property (p_keep)
    else $error("buffer select moved without cause");
  property p_thr;
    uart_tx_holding_wr |-> $past(thr_ready);
  endproperty
  a_thr: assert property (p_thr)
    else $error("holding write while not ready");
  property p_data;
    !uart_tx_holding_wr |-> $stable(uart_tx_holding_reg);
  endproperty
  a_data: assert property (p_data)
    else $error("holding data changed without write");
endmodule // dma_chk

bind uart_tx_dma_channel dma_chk dma_chk_i (.*);

// [tb/ubm_uart_model.sv]
// buffer manager, buffer memory and uart holding register model
`timescale 1ns/100ps
`include "uart_tx_dma_defs.vh"

module ubm_uart_model
(
  // clock, reset, stall control
  input wire sys_clk,
  input wire sys_rst,
  input wire slow,
  // buffer manager
  input wire buffer_select,
  input wire buf_done,
  input wire desc_wb,
  output wire ubm_buf_ready,
  output logic [`BC_W-1:0] ubm_byte_count,
  // memory and holding register
  input wire sram_rd_req,
  input wire [`BC_W-1:0] sram_rd_index,
  output logic sram_rd_valid,
  output wire [`DATA_W-1:0] sram_rd_data,
  output wire thr_ready
);
  int bufs[$];
  logic [7:0] junk;
  logic [7:0] held;
  logic [1:0] wait_n;
  logic pend;
  logic rdy_q;

  // the finished buffer must not look ready in the cycle its done pulse stands
  assign ubm_buf_ready = rdy_q && !buf_done;

  task automatic add_buf(input int n);
    bufs.push_back(n);
  endtask

  // idle lines carry a moving pattern so stale data cannot pass
  assign sram_rd_data = sram_rd_valid ? held : junk;
  assign thr_ready = !slow || junk[4];
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      junk <= 8'h00;
      held <= 8'h00;
      wait_n <= 2'h0;
      pend <= 1'b0;
      sram_rd_valid <= 1'b0;
      rdy_q <= 1'b0;
      ubm_byte_count <= 7'h00;
    end
    else
    begin
      junk <= junk + 8'h35;
      sram_rd_valid <= 1'b0;
      if (sram_rd_req)
      begin
        pend <= 1'b1;
        held <= {buffer_select, sram_rd_index};
        wait_n <= slow ? 2'h3 : 2'h0;
      end
      else if (pend && wait_n != 2'h0)
        wait_n <= wait_n - 2'h1;
      else if (pend)
      begin
        pend <= 1'b0;
        sram_rd_valid <= 1'b1;
      end
      if (buf_done || (desc_wb && bufs.size() != 0 && bufs[0] == 0))
        void'(bufs.pop_front());
      rdy_q <= bufs.size() != 0;
      ubm_byte_count <= bufs.size() != 0 ? 7'(bufs[0]) : junk[6:0];
    end
  end
endmodule // ubm_uart_model
